// *** core/icrs_pkg.sv ***
// Constants shared by the internal clock retune and settling logic
package icrs_pkg;
   localparam int BASE_FREQ_HZ = 307200;
   localparam int BASE_TOL_PCT = 25;
   localparam logic [2:0] CORR_BASE_PERIODS = 3'h4;
   localparam logic [1:0] WIN_LAST = 2'h3;
   localparam logic [6:0] MULT_RESET = 7'h15;
   localparam logic [7:0] TRIM_RESET = 8'h80;
   localparam logic [7:0] STAGE_RESET = 8'h80;
   localparam logic [3:0] DIV_RESET = 4'h0;
   localparam logic [3:0] DIV_MAX = 4'h9;
   localparam logic [11:0] CTL_MAX = 12'h9FF;
   localparam logic [11:0] STEP_COARSE = 12'h020;
   localparam logic [11:0] STEP_MEDIUM = 12'h008;
   localparam logic [11:0] STEP_FINE = 12'h001;
   localparam logic [6:0] PCT_COARSE = 7'h0F;
   localparam logic [6:0] PCT_MEDIUM = 7'h05;
   localparam logic [6:0] PCT_FULL = 7'h64;
   localparam logic [11:0] CNT_MAX = 12'hFFF;
   typedef enum logic [1:0] {
      PH_COARSE,
      PH_MEDIUM,
      PH_FINE
   } icrs_phase_t;
endpackage : icrs_pkg

// *** core/icrs_corr_window.sv ***
// Correction window: counts fast clock edges over four base periods
`timescale 1ns/1ps
module icrs_corr_window
   import icrs_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic restart,
   input wire logic base_tick,
   input wire logic fast_tick,
   output logic [11:0] fast_count,
   output logic win_done
);
   logic armed_r;
   logic [1:0] base_cnt_r;
   logic [11:0] acc_r;
   logic [11:0] acc_nxt;
   logic [2:0] seen_r;

   // Saturate so a wildly fast oscillator still reads as too fast
   assign acc_nxt = (fast_tick && acc_r != CNT_MAX) ? acc_r + 12'h001 : acc_r;

   // First base edge after a restart only aligns the window
   always_ff @(posedge mclk) begin
      if (rst || restart) begin
         armed_r <= 1'b0;
         base_cnt_r <= 2'h0;
         acc_r <= 12'h000;
         win_done <= 1'b0;
         fast_count <= 12'h000;
      end else begin
         win_done <= 1'b0;
         if (base_tick && !armed_r) begin
            armed_r <= 1'b1;
            acc_r <= 12'h000;
         end else if (base_tick && base_cnt_r == WIN_LAST) begin
            base_cnt_r <= 2'h0; // RQ6
            fast_count <= acc_nxt;
            win_done <= 1'b1;
            acc_r <= 12'h000;
         end else begin
            if (base_tick) begin
               base_cnt_r <= base_cnt_r + 2'h1;
            end
            acc_r <= acc_nxt;
         end
      end
   end

   // Helper: base edges between two windows
   always_ff @(posedge mclk) begin
      if (rst || restart || win_done) begin
         seen_r <= 3'h0;
      end else if (base_tick && armed_r && seen_r != 3'h7) begin
         seen_r <= seen_r + 3'h1;
      end
   end

   win_span_a: assert property (@(posedge mclk) disable iff (rst) // RQ6
      win_done && !$past(restart) && $past(win_done, 5) == 1'b0
         |-> $past(seen_r) == CORR_BASE_PERIODS - 3'h1 && $past(base_tick))
      else $error("window does not span four base periods");
endmodule : icrs_corr_window

// *** core/icrs_top.sv ***
// Loop filter, settling phases, stable flag and monitor enable gating
`timescale 1ns/1ps
// Behaviour
// [RQ1] Fast clock tracks multiplier times base clock
// [RQ2] Software disables monitor before changing multiplier
// [RQ3] Monitor enable refused until clock stable
// [RQ4] Software follows recommended frequency change sequence
// [RQ5] Restart settling on reset, multiplier, trim, restart
// [RQ6] Each correction spans four base periods
// [RQ7] Above fifteen percent apply coarse corrections
// [RQ8] Eight coarse steps double or halve period
// [RQ9] Medium steps between fifteen and five percent
// [RQ10] Stable flag set when medium reaches five
// [RQ11] Fine steps of one stage LSB
// [RQ12] At most thirty-two corrections after coarse phase; the code neither counts nor caps corrections
// [RQ13] Coarse correction steps stage bit five
// [RQ14] Minimum correction steps stage bit zero
// [RQ15] Stable flag clear while settling in progress
module icrs_top
   import icrs_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [6:0] mult_factor,
   input wire logic [7:0] trim_factor,
   input wire logic clock_on,
   input wire logic stop_mode,
   input wire logic base_tick,
   input wire logic fast_tick,
   input wire logic monitor_on_req,
   input wire logic monitor_off_req,
   output logic [7:0] oscillator_stage_select,
   output logic [3:0] oscillator_power_divider,
   output logic internal_clock_stable_flag,
   output logic monitor_enable_bit,
   output logic monitor_refused
);
   logic [6:0] mult_prev_r;
   logic [7:0] trim_prev_r;
   logic run_prev_r;
   logic run;
   logic restart;
   logic [11:0] fast_count;
   logic win_done;
   logic [11:0] target;
   logic [11:0] diff;
   logic too_fast;
   logic over_coarse;
   logic over_medium;
   logic [11:0] ctl;
   logic [11:0] step;
   logic [11:0] ctl_nxt;
   icrs_phase_t phase_r;
   icrs_phase_t phase_nxt;

   // Error beyond pct percent of the target count
   function automatic logic err_over(input logic [11:0] d,
                                     input logic [11:0] t,
                                     input logic [6:0] pct);
      logic [19:0] lhs;
      logic [19:0] rhs;
      lhs = 20'(d) * 20'(PCT_FULL);
      rhs = 20'(t) * 20'(pct);
      return lhs > rhs;
   endfunction : err_over

   // Divider only moves on stage carry or borrow; clamp at both ends
   function automatic logic [11:0] ctl_step(input logic [11:0] v,
                                            input logic [11:0] s,
                                            input logic up);
      logic [12:0] sum;
      sum = 13'h0000;
      if (up) begin
         sum = {1'b0, v} + {1'b0, s};
         return (sum > {1'b0, CTL_MAX}) ? CTL_MAX : sum[11:0];
      end
      return (v < s) ? 12'h000 : v - s;
   endfunction : ctl_step

   assign run = clock_on && !stop_mode;
   assign restart = (mult_factor != mult_prev_r) // RQ5
      || (trim_factor != trim_prev_r) || (run && !run_prev_r);
   assign target = {3'h0, mult_factor, 2'h0}; // RQ1
   assign too_fast = fast_count > target;
   assign diff = too_fast ? fast_count - target : target - fast_count;
   assign over_coarse = err_over(diff, target, PCT_COARSE); // RQ7
   assign over_medium = err_over(diff, target, PCT_MEDIUM);
   assign ctl = {oscillator_power_divider, oscillator_stage_select};

   always_comb begin
      phase_nxt = phase_r;
      step = 12'h000;
      case (phase_r)
         PH_COARSE: begin
            if (over_coarse) begin
               step = STEP_COARSE; // RQ13
            end else if (over_medium) begin
               step = STEP_MEDIUM;
               phase_nxt = PH_MEDIUM;
            end else begin
               phase_nxt = PH_FINE;
            end
         end
         PH_MEDIUM: begin
            if (over_medium) begin
               step = STEP_MEDIUM; // RQ9
            end else begin
               phase_nxt = PH_FINE;
            end
         end
         PH_FINE: begin
            if (diff != 12'h000) begin
               step = STEP_FINE; // RQ14
            end
         end
         default: begin
            phase_nxt = PH_COARSE;
         end
      endcase
   end

   // Too many fast edges means the period is short: lengthen it
   assign ctl_nxt = ctl_step(ctl, step, too_fast); // RQ8

   icrs_corr_window u_window (
      .mclk(mclk),
      .rst(rst),
      .restart(restart || !run),
      .base_tick(base_tick),
      .fast_tick(fast_tick),
      .fast_count(fast_count),
      .win_done(win_done)
   );

   always_ff @(posedge mclk) begin
      if (rst) begin
         mult_prev_r <= MULT_RESET;
         trim_prev_r <= TRIM_RESET;
         run_prev_r <= 1'b0;
      end else begin
         mult_prev_r <= mult_factor;
         trim_prev_r <= trim_factor;
         run_prev_r <= run;
      end
   end

   // Fine phase keeps tracking; no count limits the medium or fine corrections after coarse
   always_ff @(posedge mclk) begin
      if (rst || restart) begin
         phase_r <= PH_COARSE; // RQ5
      end else if (win_done && run) begin
         phase_r <= phase_nxt; // RQ12
      end
   end

   // Controls hold their value across restarts and while stopped
   always_ff @(posedge mclk) begin
      if (rst) begin
         oscillator_stage_select <= STAGE_RESET;
         oscillator_power_divider <= DIV_RESET;
      end else if (win_done && run && !restart) begin
         oscillator_stage_select <= ctl_nxt[7:0]; // RQ11
         oscillator_power_divider <= ctl_nxt[11:8];
      end
   end

   // A restart in the same cycle as a lock wins: the new settle begins
   always_ff @(posedge mclk) begin
      if (rst || restart || !run) begin
         internal_clock_stable_flag <= 1'b0; // RQ15
      end else if (win_done && phase_r != PH_FINE && phase_nxt == PH_FINE)
      begin
         internal_clock_stable_flag <= 1'b1; // RQ10
      end
   end

   // Once on, the monitor stays on if the clock later loses lock
   always_ff @(posedge mclk) begin
      if (rst) begin
         monitor_enable_bit <= 1'b0;
         monitor_refused <= 1'b0;
      end else begin
         monitor_refused <= monitor_on_req && !monitor_off_req
            && !internal_clock_stable_flag;
         if (monitor_off_req) begin
            monitor_enable_bit <= 1'b0;
         end else if (monitor_on_req && internal_clock_stable_flag) begin
            monitor_enable_bit <= 1'b1; // RQ3
         end
      end
   end

   sequence lock_step_s;
      win_done && run && !restart && phase_r == PH_MEDIUM && !over_medium;
   endsequence

   stable_set_a: assert property (@(posedge mclk) disable iff (rst) // RQ10
      lock_step_s |=> internal_clock_stable_flag && phase_r == PH_FINE)
      else $error("stable flag not set at medium lock");
   stable_clear_a: assert property (@(posedge mclk) disable iff (rst) // RQ15
      restart |=> !internal_clock_stable_flag && phase_r == PH_COARSE)
      else $error("settling restart did not clear stable flag");
   stable_hold_a: assert property (@(posedge mclk) disable iff (rst) // RQ15
      internal_clock_stable_flag |-> phase_r == PH_FINE)
      else $error("stable flag set outside fine phase");
   mon_refuse_a: assert property (@(posedge mclk) disable iff (rst) // RQ3
      monitor_on_req && !monitor_off_req && !internal_clock_stable_flag
         && !monitor_enable_bit |=> !monitor_enable_bit && monitor_refused)
      else $error("monitor enabled while clock unstable");
   mon_accept_a: assert property (@(posedge mclk) disable iff (rst) // RQ3
      monitor_on_req && !monitor_off_req && internal_clock_stable_flag
         |=> monitor_enable_bit && !monitor_refused)
      else $error("monitor enable not accepted when stable");
   coarse_step_a: assert property (@(posedge mclk) disable iff (rst) // RQ13
      win_done && run && !restart && phase_r == PH_COARSE && over_coarse
         && ctl > STEP_COARSE && ctl < CTL_MAX - STEP_COARSE
         |=> oscillator_stage_select[4:0] == $past(ctl[4:0])
         && oscillator_stage_select[5] != $past(ctl[5]))
      else $error("coarse correction did not step stage bit five");
   fine_step_a: assert property (@(posedge mclk) disable iff (rst) // RQ14
      win_done && run && !restart && phase_r == PH_FINE && diff != 12'h000
         && ctl != 12'h000 && ctl != CTL_MAX
         |=> $past(too_fast) ? ctl == $past(ctl) + STEP_FINE
         : ctl == $past(ctl) - STEP_FINE)
      else $error("fine correction wrong size or direction");
   div_clamp_a: assert property (@(posedge mclk) disable iff (rst) // RQ8
      oscillator_power_divider <= DIV_MAX)
      else $error("power divider beyond its maximum");
   phase_order_a: assert property (@(posedge mclk) disable iff (rst) // RQ9
      phase_r == PH_FINE && !restart |=> phase_r == PH_FINE)
      else $error("phase left fine without restart");
endmodule : icrs_top

// *** bench/tb_top.sv ***
// Self-checking bench for the clock retune and settling block
`timescale 1ns/1ps
module tb_top
   import icrs_pkg::*;
;
   typedef struct {
      int cnt;
      logic [11:0] ctl;
      logic stab;
   } icrs_row_t;
   logic mclk, rst, clock_on, stop_mode, base_tick, fast_tick;
   logic monitor_on_req, monitor_off_req, stable, mon_bit, refused;
   logic [6:0] mult_factor;
   logic [7:0] trim_factor, stage;
   logic [3:0] div;
   int num_errors = 0;
   int comparisons = 0;
   icrs_row_t rows [8];

   icrs_top dut_u (
      .mclk(mclk), .rst(rst), .mult_factor(mult_factor),
      .trim_factor(trim_factor), .clock_on(clock_on),
      .stop_mode(stop_mode), .base_tick(base_tick),
      .fast_tick(fast_tick), .monitor_on_req(monitor_on_req),
      .monitor_off_req(monitor_off_req),
      .oscillator_stage_select(stage), .oscillator_power_divider(div),
      .internal_clock_stable_flag(stable),
      .monitor_enable_bit(mon_bit), .monitor_refused(refused)
   );

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic close_out;
      $display("comparisons %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out

   task automatic chk_ctl(input logic [11:0] exp);
      comparisons++;
      if ({div, stage} !== exp) begin
         num_errors++;
         $display("wrong value at %0t: ctl %h not %h", $time,
                  {div, stage}, exp);
      end
   endtask : chk_ctl

   task automatic chk_bit(input logic got, input logic exp, input string s);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s is %b", $time, s, got);
      end
   endtask : chk_bit

   task automatic drv(input logic b, input logic f);
      @(posedge mclk);
      base_tick <= b;
      fast_tick <= f;
   endtask : drv

   // Fast pulses never share a cycle with a base pulse, so no edge case
   // in the counter decides the total
   task automatic win(input int cnt);
      int share;
      for (int i = 0; i < 4; i++) begin
         share = (i == 0) ? cnt - 3 * (cnt / 4) : cnt / 4;
         repeat (share) drv(1'b0, 1'b1);
         drv(1'b1, 1'b0);
      end
      repeat (4) drv(1'b0, 1'b0);
      #1;
   endtask : win

   task automatic mon(input logic on, input logic off);
      @(posedge mclk);
      monitor_on_req <= on;
      monitor_off_req <= off;
      @(posedge mclk);
      monitor_on_req <= 1'b0;
      monitor_off_req <= 1'b0;
      #1;
   endtask : mon

   initial begin
      #100000;
      num_errors++;
      close_out();
   end

   initial begin
      // Target is four times N = 84; steps follow the phase rules
      rows = '{'{168, 12'h0A0, 1'b0}, '{64, 12'h080, 1'b0},
               '{94, 12'h088, 1'b0}, '{90, 12'h090, 1'b0},
               '{86, 12'h090, 1'b1}, '{85, 12'h091, 1'b1},
               '{80, 12'h090, 1'b1}, '{84, 12'h090, 1'b1}};
      rst = 1'b1;
      mult_factor = 7'h15;
      trim_factor = 8'h80;
      clock_on = 1'b1;
      stop_mode = 1'b0;
      base_tick = 1'b0;
      fast_tick = 1'b0;
      monitor_on_req = 1'b0;
      monitor_off_req = 1'b0;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      #1;
      chk_ctl(12'h080);
      chk_bit(stable, 1'b0, "stable after reset");
      chk_bit(mon_bit, 1'b0, "monitor after reset");
      mon(1'b1, 1'b0);
      chk_bit(refused, 1'b1, "refusal pulse");
      chk_bit(mon_bit, 1'b0, "monitor while unstable");
      drv(1'b0, 1'b0);
      #1;
      chk_bit(refused, 1'b0, "refusal pulse end");
      repeat (2) drv(1'b0, 1'b0);
      drv(1'b1, 1'b0);
      foreach (rows[i]) begin
         win(rows[i].cnt);
         chk_ctl(rows[i].ctl);
         chk_bit(stable, rows[i].stab, "stable in settle");
      end
      mon(1'b1, 1'b0);
      chk_bit(mon_bit, 1'b1, "monitor when stable");
      chk_bit(refused, 1'b0, "no refusal when stable");
      mon(1'b1, 1'b1);
      chk_bit(mon_bit, 1'b0, "off wins over on");
      // Monitor is off here, so software may now change the multiplier
      for (int k = 0; k < 4; k++) begin
         @(posedge mclk);
         case (k)
            0: mult_factor <= 7'h0A;
            1: trim_factor <= 8'h7F;
            2: stop_mode <= 1'b1;
            default: clock_on <= 1'b0;
         endcase
         repeat (2) drv(1'b0, 1'b0);
         #1;
         chk_bit(stable, 1'b0, "stable after restart");
         chk_ctl(12'h090);
         @(posedge mclk);
         stop_mode <= 1'b0;
         clock_on <= 1'b1;
         repeat (3) drv(1'b0, 1'b0);
         drv(1'b1, 1'b0);
         // Exact count for the new N locks at once with no step
         win(4 * mult_factor);
         chk_bit(stable, 1'b1, "stable after resettle");
         chk_ctl(12'h090);
         if (k == 0) begin
            mon(1'b1, 1'b0);
            chk_bit(mon_bit, 1'b1, "monitor back after retune");
         end
      end
      chk_bit(mon_bit, 1'b1, "monitor kept over lost lock");
      mon(1'b0, 1'b1);
      chk_bit(mon_bit, 1'b0, "monitor off before retune");
      @(posedge mclk);
      mult_factor <= 7'h15;
      repeat (2) drv(1'b0, 1'b0);
      mon(1'b1, 1'b0);
      chk_bit(refused, 1'b1, "refusal after retune");
      chk_bit(mon_bit, 1'b0, "monitor held off after retune");
      close_out();
   end
endmodule : tb_top
